// *** fdt_pkg.sv ***
// Package of constants and types for the fault detect and totalizer block.
package fdt_pkg;

  // Channel counts.
  localparam int NCELL = 12;
  localparam int NWIRE = 13;
  localparam int NTEMP = 5;
  localparam int NFILT = 2 * NCELL + 2;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_SETUP  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OV     = 8'h08;
  localparam logic [7:0] ADDR_UV     = 8'h0C;
  localparam logic [7:0] ADDR_OW     = 8'h10;
  localparam logic [7:0] ADDR_OT     = 8'h14;
  localparam logic [7:0] ADDR_CTRL   = 8'h18;

  // Fault setup word layout and reset value.
  localparam int SETUP_W    = 13;
  localparam int SCN_LSB    = 0;
  localparam int WIRE_SCAN_FOLLOW_BIT_BIT   = 4;
  localparam int TOT_LSB    = 5;
  localparam int TEMPEN_LSB = 8;
  localparam logic [12:0] SETUP_RESET = 13'h0000;

  // Fault status word layout.
  localparam int STATUS_W = 8;
  localparam int ST_REG   = 0;
  localparam int ST_OSC   = 1;
  localparam int ST_OV    = 2;
  localparam int ST_UV    = 3;
  localparam int ST_OT    = 4;
  localparam int ST_OW    = 5;
  localparam int ST_PACK  = 6;
  localparam int ST_GND   = 7;

  // Control word layout and reset value.
  localparam int CTRL_CONT_BIT = 0;
  localparam logic CTRL_RESET  = 1'b0;

  // Scan interval timing: base period in ms, largest code, millisecond tick.
  localparam logic [15:0] SCAN_BASE_MS  = 16'h0010;
  localparam logic [3:0]  SCAN_CODE_MAX = 4'hB;
  localparam int CLOCK_HZ    = 40_000_000;
  localparam int TICK_MS     = 1;
  localparam int MS_CYCLES_DEF = CLOCK_HZ / 1000 * TICK_MS;

  // Continuous scan sequence states; one bit changes per step except TEMP back to IDLE.
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_VOLT = 2'b01,
    SC_TEMP = 2'b11
  } fdt_scan_t;

endpackage

// *** fdt_fault_totalizer.sv ***
// Fault detection, totalizing filters and fault setup registers on APB.
//
// Summary of operation
// - Supply and reference window comparators out of range set the supply fault at once.
// - Oscillator mismatch beyond limit sets the oscillator fault and alarms at once.
// - One fault bit per cell, wire or temperature input for each fault type, ORed into status summaries.
// - Open pack supply and open ground each have one status bit.
// - Cell, pack, ground, wire and temperature checks happen only when a scan or single cell measurement completes, host-started or continuous.
// - Voltage scan end samples overvoltage, undervoltage, pack and ground together.
// - Single cell measurement also evaluates overvoltage and undervoltage.
// - Continuous scanning re-evaluates faults every interval without host commands.
// - Fault is valid after 2 to the power of the run field consecutive positives.
// - Every cell, pack supply and ground test has its own filter.
// - A negative test result returns that filter count to zero.
// - Any change of the fault status word clears all filters.
// - Any validated fault starts the alarm response.
// - Continuous detection time equals scan interval times filter run length.
// - Four-bit scan period field doubles from 16 ms to 32768 ms.
// - Bit 4 makes wire scans follow voltage scans or temperature scans.
// - Bit 8 enables internal temperature, bits 9 to 12 external inputs.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps

module fdt_fault_totalizer
  import fdt_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Asynchronous comparator results.
  input  wire logic [NCELL-1:0]  cell_ov_raw,
  input  wire logic [NCELL-1:0]  cell_uv_raw,
  input  wire logic [NWIRE-1:0]  wire_open_raw,
  input  wire logic [NTEMP-1:0]  temp_over_raw,
  input  wire logic              pack_open_raw,
  input  wire logic              gnd_open_raw,
  input  wire logic              internal_rail_high_bad,
  input  wire logic              internal_rail_low_bad,
  input  wire logic              reference_bad,
  input  wire logic              oscillator_fault_raw,
  // Scan sequencer completion strobes, same clock.
  input  wire logic              volt_scan_done,
  input  wire logic              cell_measure_done,
  input  wire logic              wire_scan_done,
  input  wire logic              temp_scan_done,
  // Scan requests and alarm.
  output logic                   volt_scan_start,
  output logic                   temp_scan_start,
  output logic                   wire_scan_start,
  output logic                   alarm_start
);

  localparam int RAW_W = 2 * NCELL + NWIRE + NTEMP + 6;

  logic [1:0]        rst_pipe_reg;
  logic              rst_sync_b;
  logic [RAW_W-1:0]  raw_w, s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [SETUP_W-1:0] setup_reg;
  logic              ctrl_cont_reg;
  logic [NCELL-1:0]  ov_reg, uv_reg, ov_next, uv_next, ov_keep, uv_keep;
  logic [NWIRE-1:0]  ow_reg, ow_next, ow_keep, ow_set;
  logic [NTEMP-1:0]  ot_reg, ot_next, ot_keep, ot_set, temp_en_w;
  logic [3:0]        flag_reg, flag_next, flag_keep, flag_set;
  logic [STATUS_W-1:0] status_w, status_next_w;
  logic              filt_clear_w, new_fault_w;
  logic [NFILT-1:0]  tst_w, samp_w, hit_w;
  logic [7:0]        cnt_reg [NFILT];
  logic [7:0]        run_len_w;
  logic [3:0]        scn_code_w;
  logic [15:0]       period_w, ms_cnt_reg, iv_cnt_reg;
  logic              ms_tick_w, iv_tick_w;
  fdt_scan_t         scan_state_reg, scan_state_next;
  logic              go_volt_w, go_temp_w;
  logic              access_w, done_w, wr_w, addr_ok_w;
  logic              wr_setup, wr_status, wr_ov, wr_uv, wr_ow, wr_ot, wr_ctrl;
  logic [31:0]       rd_w;

  // Reset release through two flip-flops.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rst_pipe_reg <= 2'b00;
    else        rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_sync_b = rst_pipe_reg[1];

  // Comparator levels enter through three flops; a change counts once stages two and three agree.
  assign raw_w = {oscillator_fault_raw, reference_bad, internal_rail_low_bad,
                  internal_rail_high_bad, gnd_open_raw, pack_open_raw, temp_over_raw,
                  wire_open_raw, cell_uv_raw, cell_ov_raw};
  assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= raw_w;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // APB decode; one wait state, so each access phase lasts two cycles.
  assign access_w  = psel & penable;
  assign done_w    = access_w & pready;
  assign wr_w      = done_w & pwrite;
  assign wr_setup  = wr_w & (paddr == ADDR_SETUP);
  assign wr_status = wr_w & (paddr == ADDR_STATUS);
  assign wr_ov     = wr_w & (paddr == ADDR_OV);
  assign wr_uv     = wr_w & (paddr == ADDR_UV);
  assign wr_ow     = wr_w & (paddr == ADDR_OW);
  assign wr_ot     = wr_w & (paddr == ADDR_OT);
  assign wr_ctrl   = wr_w & (paddr == ADDR_CTRL);
  assign addr_ok_w = (paddr == ADDR_SETUP) | (paddr == ADDR_STATUS) | (paddr == ADDR_OV) |
                     (paddr == ADDR_UV) | (paddr == ADDR_OW) | (paddr == ADDR_OT) |
                     (paddr == ADDR_CTRL);

  // Read data selection; unmapped addresses read zero.
  assign rd_w = (paddr == ADDR_SETUP)  ? {19'h00000, setup_reg} :
                (paddr == ADDR_STATUS) ? {24'h000000, status_w} :
                (paddr == ADDR_OV)     ? {20'h00000, ov_reg} :
                (paddr == ADDR_UV)     ? {20'h00000, uv_reg} :
                (paddr == ADDR_OW)     ? {19'h00000, ow_reg} :
                (paddr == ADDR_OT)     ? {27'h0000000, ot_reg} :
                (paddr == ADDR_CTRL)   ? {31'h00000000, ctrl_cont_reg} : 32'h00000000;

  // Bus answer flops: data and error are loaded in the first access cycle.
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access_w & ~pready;
      pslverr <= access_w & ~pready & ~addr_ok_w;
      if (access_w & ~pready) prdata <= rd_w;
    end
  end

  // Setup and control registers.
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      setup_reg     <= SETUP_RESET;
      ctrl_cont_reg <= CTRL_RESET;
    end else begin
      if (wr_setup) setup_reg <= pwdata[SETUP_W-1:0];
      if (wr_ctrl)  ctrl_cont_reg <= pwdata[CTRL_CONT_BIT];
    end
  end

  // Fields of the setup word.
  assign run_len_w  = 8'h01 << setup_reg[TOT_LSB +: 3];
  assign temp_en_w  = setup_reg[TEMPEN_LSB +: NTEMP];
  assign scn_code_w = (setup_reg[SCN_LSB +: 4] > SCAN_CODE_MAX) ? SCAN_CODE_MAX
                                                                 : setup_reg[SCN_LSB +: 4];
  assign period_w   = SCAN_BASE_MS << scn_code_w;

  // Filter inputs: cells first, then pack supply and ground, all sampled on scan ends.
  assign tst_w = {filt_reg[2*NCELL+NWIRE+NTEMP+1], filt_reg[2*NCELL+NWIRE+NTEMP],
                  filt_reg[2*NCELL-1:0]};
  assign samp_w = {{2{volt_scan_done}},
                   {(2*NCELL){volt_scan_done | cell_measure_done}}};

  // One totalizing filter per test.
  genvar gi;
  generate
    for (gi = 0; gi < NFILT; gi++) begin : g_filt
      logic [7:0] inc_w;
      assign inc_w = (cnt_reg[gi] >= run_len_w) ? run_len_w : cnt_reg[gi] + 8'h01;
      assign hit_w[gi] = samp_w[gi] & tst_w[gi] & (inc_w >= run_len_w);
      always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)       cnt_reg[gi] <= 8'h00;
        else if (filt_clear_w) cnt_reg[gi] <= 8'h00;
        else if (samp_w[gi])   cnt_reg[gi] <= tst_w[gi] ? inc_w : 8'h00;
      end
    end
  endgenerate

  // Set sources; supply and oscillator supervision run every cycle.
  assign flag_set = {hit_w[NFILT-1], hit_w[NFILT-2], filt_reg[RAW_W-1],
                     |filt_reg[RAW_W-2:RAW_W-4]};
  assign ow_set = wire_scan_done ? filt_reg[2*NCELL +: NWIRE] : '0;
  assign ot_set = temp_scan_done ? (filt_reg[2*NCELL+NWIRE +: NTEMP] & temp_en_w) : '0;

  // Keep masks: a rewrite clears, a zero status summary clears its register.
  assign ov_keep   = wr_ov ? pwdata[NCELL-1:0] : wr_status ? {NCELL{pwdata[ST_OV]}} : '1;
  assign uv_keep   = wr_uv ? pwdata[NCELL-1:0] : wr_status ? {NCELL{pwdata[ST_UV]}} : '1;
  assign ow_keep   = wr_ow ? pwdata[NWIRE-1:0] : wr_status ? {NWIRE{pwdata[ST_OW]}} : '1;
  assign ot_keep   = wr_ot ? pwdata[NTEMP-1:0] : wr_status ? {NTEMP{pwdata[ST_OT]}} : '1;
  assign flag_keep = wr_status ? {pwdata[ST_GND], pwdata[ST_PACK], pwdata[ST_OSC],
                                  pwdata[ST_REG]} : 4'hF;

  // Sticky next values; a set in the clearing cycle wins.
  assign ov_next   = (ov_reg & ov_keep) | hit_w[NCELL-1:0];
  assign uv_next   = (uv_reg & uv_keep) | hit_w[2*NCELL-1:NCELL];
  assign ow_next   = (ow_reg & ow_keep) | ow_set;
  assign ot_next   = (ot_reg & ot_keep) | ot_set;
  assign flag_next = (flag_reg & flag_keep) | flag_set;

  // Status word with one summary bit per data register.
  assign status_w = {flag_reg[3], flag_reg[2], |ow_reg, |ot_reg, |uv_reg, |ov_reg,
                     flag_reg[1], flag_reg[0]};
  assign status_next_w = {flag_next[3], flag_next[2], |ow_next, |ot_next, |uv_next,
                          |ov_next, flag_next[1], flag_next[0]};
  assign filt_clear_w  = (status_next_w != status_w);
  assign new_fault_w   = |(flag_set & ~flag_reg) | |(hit_w[NCELL-1:0] & ~ov_reg) |
                         |(hit_w[2*NCELL-1:NCELL] & ~uv_reg) | |(ow_set & ~ow_reg) |
                         |(ot_set & ~ot_reg);

  // Fault registers and alarm pulse.
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ov_reg      <= '0;
      uv_reg      <= '0;
      ow_reg      <= '0;
      ot_reg      <= '0;
      flag_reg    <= 4'h0;
      alarm_start <= 1'b0;
    end else begin
      ov_reg      <= ov_next;
      uv_reg      <= uv_next;
      ow_reg      <= ow_next;
      ot_reg      <= ot_next;
      flag_reg    <= flag_next;
      alarm_start <= new_fault_w;
    end
  end

  // Millisecond tick and scan interval counter for continuous scanning.
  assign ms_tick_w = (ms_cnt_reg == 16'(MS_CYCLES - 1));
  assign iv_tick_w = ctrl_cont_reg & ms_tick_w & (iv_cnt_reg >= period_w - 16'h0001);
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ms_cnt_reg <= 16'h0000;
      iv_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_tick_w ? 16'h0000 : ms_cnt_reg + 16'h0001;
      if (!ctrl_cont_reg || iv_tick_w) iv_cnt_reg <= 16'h0000;
      else if (ms_tick_w)              iv_cnt_reg <= iv_cnt_reg + 16'h0001;
    end
  end

  // Scan sequence: voltage scan each interval, then the temperature scan.
  assign go_volt_w = (scan_state_reg == SC_IDLE) & iv_tick_w;
  assign go_temp_w = (scan_state_reg == SC_VOLT) & volt_scan_done;
  always_comb begin
    case (scan_state_reg)
      SC_IDLE: scan_state_next = go_volt_w ? SC_VOLT : SC_IDLE;
      SC_VOLT: scan_state_next = volt_scan_done ? SC_TEMP : SC_VOLT;
      SC_TEMP: scan_state_next = temp_scan_done ? SC_IDLE : SC_TEMP;
      default: scan_state_next = SC_IDLE;
    endcase
  end

  // Scan request pulses; wire scans follow the schedule picked in the setup word.
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scan_state_reg  <= SC_IDLE;
      volt_scan_start <= 1'b0;
      temp_scan_start <= 1'b0;
      wire_scan_start <= 1'b0;
    end else begin
      scan_state_reg  <= scan_state_next;
      volt_scan_start <= go_volt_w;
      temp_scan_start <= go_temp_w;
      wire_scan_start <= setup_reg[WIRE_SCAN_FOLLOW_BIT_BIT] ? go_temp_w : go_volt_w;
    end
  end

  // Checks of the fault logic.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  supply_fault_a: assert property (filt_reg[RAW_W-4] |=> flag_reg[0])
    else $error("supply fault flag not set");
  osc_fault_a: assert property (filt_reg[RAW_W-1] && !flag_reg[1] |=> alarm_start)
    else $error("oscillator fault did not alarm");
  summary_read_a: assert property (access_w && !pready && paddr == ADDR_STATUS
      |=> prdata[ST_OV] == |$past(ov_reg) && prdata[ST_OW] == |$past(ow_reg))
    else $error("status summary does not match data registers");
  pack_bit_a: assert property (hit_w[NFILT-2] |=> flag_reg[2] && status_w[ST_PACK])
    else $error("pack supply open bit missing");
  no_spont_a: assert property (!volt_scan_done && !cell_measure_done && !filt_clear_w
      |=> cnt_reg[0] == $past(cnt_reg[0]))
    else $error("filter moved without a scan");
  meas_eval_a: assert property (cell_measure_done && tst_w[NCELL] && run_len_w == 8'h01
      |=> uv_reg[0])
    else $error("measure did not evaluate undervoltage");
  run_valid_a: assert property (volt_scan_done && tst_w[0] && !filt_clear_w
      && cnt_reg[0] + 8'h01 < run_len_w |=> !ov_reg[0] || $past(ov_reg[0]))
    else $error("fault validated before full run");
  neg_reset_a: assert property (samp_w[1] && !tst_w[1] |=> cnt_reg[1] == 8'h00)
    else $error("negative sample did not zero filter");
  status_clr_a: assert property (filt_clear_w |=> cnt_reg[0] == 8'h00
      && cnt_reg[NFILT-1] == 8'h00)
    else $error("filters not cleared on status change");
  sticky_bit_a: assert property (ov_reg[0] && !wr_ov && !wr_status |=> ov_reg[0])
    else $error("fault bit dropped without host write");
  cont_scan_a: assert property (iv_tick_w && scan_state_reg == SC_IDLE
      |=> volt_scan_start ##1 !volt_scan_start)
    else $error("continuous scan not started");

  volt_hit_c: cover property (volt_scan_done && |hit_w);
  status_clr_c: cover property (wr_status && |status_w);
  cont_cycle_c: cover property (scan_state_reg == SC_TEMP && temp_scan_done);

endmodule // fdt_fault_totalizer

// *** fdt_scan_model.sv ***
// Scan sequencer model that answers each scan request after a fixed delay.
`timescale 1ns/1ps

module fdt_scan_model #(
  parameter int DLY = 5
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Requests in volt, temp, wire order and their completions.
  input  wire logic [2:0] start,
  output logic      [2:0] done
);
  int cnt [3];

  // Each lane counts down from a request and then pulses done for one cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    for (int i = 0; i < 3; i++) begin
      done[i] <= 1'b0;
      if (!rst_b) begin
        cnt[i] <= 0;
      end else if (start[i]) begin
        cnt[i] <= DLY;
      end else if (cnt[i] == 1) begin
        cnt[i]  <= 0;
        done[i] <= 1'b1;
      end else if (cnt[i] > 1) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule // fdt_scan_model

// *** fdt_fault_totalizer_tb.sv ***
// Self-checking bench for the fault detect and totalizer block.
`timescale 1ns/1ps

module fdt_fault_totalizer_tb
  import fdt_pkg::*;
;
  typedef struct packed {logic [2:0] code; int n;} fdt_row_t;
  localparam int MSC   = 4;
  localparam int LIMIT = 20000;
  logic             clock = 1'b0;
  logic             rst_b = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, r;
  logic             pready, pslverr, alarm, e;
  logic [NCELL-1:0] ov = '0, uv = '0;
  logic [NWIRE-1:0] ow = '0;
  logic [NTEMP-1:0] ot = '0;
  logic             pack = 1'b0, gnd = 1'b0;
  logic [3:0]       sup = 4'h0;
  logic [3:0]       dn = 4'h0;
  wire  [2:0]       st;
  logic [2:0]       md;
  int               failures = 0, checks = 0, cyc = 0, alarms = 0;
  int               wv = 0, wt = 0, tst = 0, a, b, c;
  fdt_row_t rows [5] = '{'{3'h0, 1}, '{3'h1, 2}, '{3'h2, 4}, '{3'h3, 8}, '{3'h7, 128}};

  // Design under test; bench strobes are merged with the scan model's.
  fdt_fault_totalizer #(.MS_CYCLES(MSC)) dut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_ov_raw(ov), .cell_uv_raw(uv), .wire_open_raw(ow), .temp_over_raw(ot),
    .pack_open_raw(pack), .gnd_open_raw(gnd), .internal_rail_high_bad(sup[0]),
    .internal_rail_low_bad(sup[1]), .reference_bad(sup[2]), .oscillator_fault_raw(sup[3]),
    .volt_scan_done(dn[0] | md[0]), .cell_measure_done(dn[1]),
    .wire_scan_done(dn[2] | md[2]), .temp_scan_done(dn[3] | md[1]),
    .volt_scan_start(st[0]), .temp_scan_start(st[1]), .wire_scan_start(st[2]),
    .alarm_start(alarm));

  // Far-side scan sequencer answering the continuous scan requests.
  fdt_scan_model model (.clock(clock), .rst_b(rst_b), .start(st), .done(md));

  // Free-running clock.
  initial forever #12.5 clock = ~clock;

  // Counts cycles, alarm pulses and scan requests, and cuts a hang short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (alarm === 1'b1) alarms <= alarms + 1;
    if (st[0] === 1'b1 && st[2] === 1'b1) wv <= wv + 1;
    if (st[1] === 1'b1 && st[2] === 1'b1) wt <= wt + 1;
    if (st[1] === 1'b1) tst <= tst + 1;
    if (cyc == LIMIT) begin
      failures = failures + 1;
      stop_test();
    end
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(r, x);
  endtask

  // Host reissues the scan strobe for each fresh check, then lets it land.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clock);
      dn[k] <= 1'b1;
      @(posedge clock);
      dn[k] <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic wait_sync();
    repeat (6) @(posedge clock);
  endtask

  // Waits for a volt scan request.
  task automatic wstart();
    @(posedge clock);
    while (st[0] !== 1'b1) @(posedge clock);
  endtask

  // Measures the spacing of continuous volt scan requests.
  task automatic vper(input int exp);
    int t;
    wstart();
    wstart();
    t = cyc;
    wstart();
    chk(cyc - t, exp);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: reset, register access, filter rows, then the awkward cases.
  initial begin
    repeat (12) @(posedge clock);
    chk({26'h0, pready, pslverr, st, alarm}, 32'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd(ADDR_SETUP, {19'h0, SETUP_RESET});
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    wr(ADDR_SETUP, 32'hFFFF_FFFF);
    rd(ADDR_SETUP, 32'h1FFF);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(e, 1'b1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(r, 32'h0);
    ov <= 12'h001;
    foreach (rows[i]) begin
      wr(ADDR_SETUP, {24'h0, rows[i].code, 5'h0});
      a = alarms;
      pulse(0, rows[i].n - 1);
      rd(ADDR_STATUS, 32'h0);
      pulse(0, 1);
      rd(ADDR_STATUS, 32'h04);
      rd(ADDR_OV, 32'h001);
      chk(alarms - a, 1);
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_OV, 32'h0);
    end
    // A negative sample restarts only its own filter.
    wr(ADDR_SETUP, 32'h40);
    ov <= 12'h003;
    wait_sync();
    pulse(0, 3);
    ov <= 12'h002;
    wait_sync();
    pulse(0, 1);
    rd(ADDR_OV, 32'h002);
    ov <= 12'h001;
    wr(ADDR_STATUS, 32'h0);
    pulse(0, 2);
    sup <= 4'h4;
    wait_sync();
    sup <= 4'h0;
    pulse(0, 2);
    rd(ADDR_OV, 32'h0);
    pulse(0, 2);
    rd(ADDR_OV, 32'h001);
    ov <= 12'h000;
    wr(ADDR_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      a = alarms;
      sup <= 4'h1 << i;
      wait_sync();
      sup <= 4'h0;
      rd(ADDR_STATUS, (i == 3) ? 32'h2 : 32'h1);
      chk(alarms - a, 1);
      wr(ADDR_STATUS, 32'h0);
    end
    wr(ADDR_SETUP, 32'h0);
    uv <= '1;
    repeat (20) @(posedge clock);
    rd(ADDR_STATUS, 32'h0);
    pulse(1, 1);
    rd(ADDR_UV, 32'hFFF);
    rd(ADDR_STATUS, 32'h08);
    uv <= '0;
    pack <= 1'b1;
    gnd <= 1'b1;
    wr(ADDR_STATUS, 32'h0);
    pulse(1, 1);
    rd(ADDR_STATUS, 32'h0);
    pulse(0, 1);
    rd(ADDR_STATUS, 32'hC0);
    pack <= 1'b0;
    gnd <= 1'b0;
    wait_sync();
    rd(ADDR_STATUS, 32'hC0);
    wr(ADDR_STATUS, 32'h0);
    ow <= 13'h1000;
    ot <= 5'h1F;
    wait_sync();
    pulse(2, 1);
    // Host lets the cell inputs settle after a wire scan before using cell data.
    repeat (3 * MSC) @(posedge clock);
    rd(ADDR_OW, 32'h1000);
    pulse(3, 1);
    rd(ADDR_OT, 32'h0);
    wr(ADDR_SETUP, 32'h500);
    pulse(3, 1);
    rd(ADDR_OT, 32'h05);
    rd(ADDR_STATUS, 32'h30);
    ow <= '0;
    ot <= '0;
    wait_sync();
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_SETUP, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    a = wv;
    b = wt;
    c = tst;
    vper(16 * MSC);
    chk(wv > a, 1'b1);
    chk(wt - b, 0);
    chk(tst > c, 1'b1);
    wr(ADDR_SETUP, 32'h11);
    vper(32 * MSC);
    a = wv;
    b = wt;
    vper(32 * MSC);
    chk(wt > b, 1'b1);
    chk(wv - a, 0);
    // Continuous detection needs as many scan intervals as the run length.
    wr(ADDR_SETUP, 32'h20);
    wstart();
    ov <= 12'h001;
    wstart();
    rd(ADDR_OV, 32'h0);
    wstart();
    rd(ADDR_OV, 32'h001);
    ov <= 12'h000;
    wr(ADDR_CTRL, 32'h0);
    stop_test();
  end
endmodule // fdt_fault_totalizer_tb
